/* rtl/alg_defs.vh */
// Offsets, field positions, reset values and counts of the global registers
`ifndef ALG_DEFS_VH
`define ALG_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ALG_OFS_OUT_PAYLOAD 9'h004
`define ALG_OFS_IN_PAYLOAD 9'h006
`define ALG_OFS_GLOBAL_CTRL 9'h008
`define ALG_OFS_WAKE_EN 9'h00c
`define ALG_OFS_STATE_STS 9'h00e
`define ALG_OFS_GLOBAL_STS 9'h010
`define ALG_OFS_IRQ_CTRL 9'h020
`define ALG_OFS_IRQ_STS 9'h024

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define ALG_OUT_PAYLOAD_VAL 16'h003c
`define ALG_IN_PAYLOAD_VAL 16'h001d
`define ALG_GLOBAL_CONTROL_RESET 32'h0000_0000
`define ALG_WAKE_EN_RESET 3'h0
`define ALG_STATE_STS_RESET 3'h0
`define ALG_IRQ_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALG_GLOBAL_CONTROL_CRST_BIT 0
`define ALG_GLOBAL_CONTROL_FLUSH_BIT 1
`define ALG_GLOBAL_CONTROL_UNSOL_BIT 8
`define ALG_GLOBAL_STATUS_FLUSH_BIT 1
`define ALG_STATE_STS_SHIFT 16
`define ALG_GIE_BIT 31
`define ALG_CIE_BIT 30
`define ALG_GIS_BIT 31
`define ALG_CIS_BIT 30
`define ALG_LINE_COUNT 3
`define ALG_STREAM_COUNT 8

// ----------------------------------------------------------------
// Reset sequencing, in link clock rising edges
// ----------------------------------------------------------------
`define ALG_RST_ENTER_EDGES 4
`define ALG_RST_EXIT_EDGES 4

`endif

/* rtl/alg_sync.v */
// Two-flop synchroniser for inputs from outside the system clock
`timescale 1ns/1ps
module alg_sync #(
	parameter WIDTH = 4
) (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire [WIDTH-1:0] asyncIn,
	output reg [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stage1_r;

	// First stage feeds only the second
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			stage1_r <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end

endmodule // alg_sync

/* rtl/alg_rst_seq.v */
// Controller reset sequencer driving the link reset
`timescale 1ns/1ps
`include "alg_defs.vh"
module alg_rst_seq #(
	parameter ENTER_EDGES = `ALG_RST_ENTER_EDGES,
	parameter EXIT_EDGES = `ALG_RST_EXIT_EDGES,
	parameter CNT_W = 8
) (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire runReq,
	input wire linkEdge,
	output reg ready,
	output reg linkResetN
);

	localparam ST_RESET = 2'b00;
	localparam ST_EXIT = 2'b01;
	localparam ST_RUN = 2'b10;
	localparam ST_ENTER = 2'b11;

	reg [1:0] state_r;
	reg [CNT_W-1:0] edgeCnt_r;

	// ----------------------------------------------------------------
	// Sequencing into and out of reset, counted on link edges
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_r <= ST_RESET;
			edgeCnt_r <= {CNT_W{1'b0}};
			ready <= 1'b0;
			linkResetN <= 1'b0;
		end
		else if (ce)
		begin
			case (state_r)
			ST_RESET:
			begin
				ready <= 1'b0;
				linkResetN <= 1'b0;
				edgeCnt_r <= {CNT_W{1'b0}};
				if (runReq)
				begin
					state_r <= ST_EXIT;
					linkResetN <= 1'b1;
				end
			end
			ST_EXIT:
			begin
				if (!runReq)
				begin
					state_r <= ST_ENTER;
					linkResetN <= 1'b0;
					edgeCnt_r <= {CNT_W{1'b0}};
				end
				else if (linkEdge)
				begin
					if (edgeCnt_r == EXIT_EDGES[CNT_W-1:0] - 1'b1)
					begin
						state_r <= ST_RUN;
						ready <= 1'b1;
					end
					edgeCnt_r <= edgeCnt_r + 1'b1;
				end
			end
			ST_RUN:
			begin
				if (!runReq)
				begin
					state_r <= ST_ENTER;
					ready <= 1'b0;
					linkResetN <= 1'b0;
					edgeCnt_r <= {CNT_W{1'b0}};
				end
			end
			ST_ENTER:
			begin
				// Bit already reads back 0 here, before sequencing is done
				if (linkEdge)
				begin
					if (edgeCnt_r == ENTER_EDGES[CNT_W-1:0] - 1'b1)
						state_r <= ST_RESET;
					edgeCnt_r <= edgeCnt_r + 1'b1;
				end
			end
			default:
			begin
				state_r <= ST_RESET;
				ready <= 1'b0;
				linkResetN <= 1'b0;
			end
			endcase
		end
	end

endmodule // alg_rst_seq

/* rtl/alg_global_regs.v */
// Global register set of the serial audio link controller
`timescale 1ns/1ps
`include "alg_defs.vh"

// Functional notes
// - Output payload reads fixed 60 words
// - Input payload reads fixed 29 words
// - Unsolicited responses accepted only when enabled
// - Flush start; completion sets status, clears control
// - Reset bit 0 resets logic, asserts link reset
// - Reset bit reads 0 once ready drops, before reset sequencing
// - Reset bit 1 releases link, reads 1 ready
// - In reset, accesses ignored except reset release
// - Wake enable lets each line raise wake
// - Wake and change flags reset only at power-on, kept over controller reset
// - Line change flags set by event, write-1 clear
// - Global enable gates all interrupts
// - Controller enable gates controller interrupt causes
// - Stream enables gate each stream's interrupt
// - Bits 0-3 input streams, 4-7 output
// - Global status is OR of all status
// - Controller status independent of its enable
// - Stream status is OR, independent of enable
module alg_global_regs #(
	parameter ENTER_EDGES = `ALG_RST_ENTER_EDGES,
	parameter EXIT_EDGES = `ALG_RST_EXIT_EDGES,
	parameter LINES = `ALG_LINE_COUNT,
	parameter STREAMS = `ALG_STREAM_COUNT
) (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire regWrEn,
	input wire regRdEn,
	input wire [8:0] regAddr,
	input wire [31:0] regWrData,
	input wire [3:0] regByteEn,
	output reg [31:0] regRdData,
	output reg regAck,
	input wire linkBitClk,
	input wire [2:0] serialInLine,
	output wire linkResetN,
	output wire linkEnable,
	input wire unsolRespValid,
	output reg unsolRespPush,
	output reg unsolRespDrop,
	output reg flushReq,
	input wire flushDone,
	input wire respIrq,
	input wire respOverrun,
	input wire [7:0] streamIocSts,
	input wire [7:0] streamFifoErrSts,
	output reg irqOut,
	output reg wakeEvent
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Byte-lane merge of write data into a stored word
	function [31:0] byteMerge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0] be;
		integer i;
		begin
			byteMerge = oldVal;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					byteMerge[i*8 +: 8] = newVal[i*8 +: 8];
		end
	endfunction

	// Word match of a byte offset against the access address
	function wordHit;
		input [8:0] addr;
		input [8:0] ofs;
		begin
			wordHit = (addr[8:2] == ofs[8:2]);
		end
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	wire [3:0] syncIn;
	wire [3:0] syncOut;
	wire linkClkS;
	wire [2:0] lineS;
	reg linkClkPrev_r;
	wire linkEdge;
	reg [2:0] lineSamp_r;
	wire [2:0] lineEvt;
	wire seqReady;
	wire ctrlInRst;

	reg crstReq_r;
	reg flushCtl_r;
	reg unsolEn_r;
	reg flushSts_r;
	reg [2:0] wake_enable_r;
	reg [2:0] line_state_change_status_r;
	reg gie_r;
	reg cie_r;
	reg [7:0] sie_r;

	wire anyAccess;
	wire wrOk;
	wire wrGctl;
	wire wrWake;
	wire wrGsts;
	wire wrIrqCtl;
	wire [31:0] gctlMerged;
	wire [31:0] wakeMerged;
	wire [31:0] gstsMerged;
	wire [31:0] irqMerged;
	wire [2:0] stateClr;
	wire flushStsClr;
	wire [7:0] stream_irq_status;
	wire controller_irq_status;
	wire global_irq_status;
	reg [31:0] readWord;

	// ----------------------------------------------------------------
	// Link clock and serial input lines
	// ----------------------------------------------------------------

	// Both come from the link side, so they are synchronised first
	assign syncIn = {serialInLine, linkBitClk};
	alg_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);
	assign linkClkS = syncOut[0];
	assign lineS = syncOut[3:1];

	// Rising edge of the link clock, sampling point for the lines
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			linkClkPrev_r <= 1'b0;
			lineSamp_r <= 3'h0;
		end
		else if (ce)
		begin
			linkClkPrev_r <= linkClkS;
			if (linkEdge)
				lineSamp_r <= lineS;
		end
	end
	assign linkEdge = linkClkS & ~linkClkPrev_r;

	// A line rising between link edges is a state change event
	assign lineEvt = linkEdge ? (lineS & ~lineSamp_r) : 3'h0;

	// ----------------------------------------------------------------
	// Controller reset sequencing
	// ----------------------------------------------------------------
	alg_rst_seq #(
		.ENTER_EDGES(ENTER_EDGES),
		.EXIT_EDGES(EXIT_EDGES)
	) u_rst_seq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.runReq(crstReq_r),
		.linkEdge(linkEdge),
		.ready(seqReady),
		.linkResetN(linkResetN)
	);
	assign linkEnable = seqReady; // Other link signals idle in reset
	assign ctrlInRst = ~seqReady;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------

	// Only the reset release gets through while not ready
	assign anyAccess = regWrEn | regRdEn;
	assign wrOk = regWrEn & seqReady;
	assign wrGctl = wrOk & wordHit(regAddr, `ALG_OFS_GLOBAL_CTRL);
	assign wrWake = wrOk & wordHit(regAddr, `ALG_OFS_WAKE_EN);
	assign wrGsts = wrOk & wordHit(regAddr, `ALG_OFS_GLOBAL_STS);
	assign wrIrqCtl = wrOk & wordHit(regAddr, `ALG_OFS_IRQ_CTRL);

	assign gctlMerged = byteMerge({23'h0, unsolEn_r, 6'h0, flushCtl_r,
		crstReq_r}, regWrData, regByteEn);
	assign wakeMerged = byteMerge({16'h0, 13'h0, wake_enable_r}, regWrData,
		regByteEn);
	assign gstsMerged = byteMerge(32'h0000_0000, regWrData, regByteEn);
	assign irqMerged = byteMerge({gie_r, cie_r, 22'h0, sie_r}, regWrData,
		regByteEn);

	// Write-one-to-clear strobes, only on enabled lanes
	assign stateClr = (wrWake & regByteEn[2]) ?
		regWrData[`ALG_STATE_STS_SHIFT +: 3] : 3'h0;
	assign flushStsClr = wrGsts & gstsMerged[`ALG_GLOBAL_STATUS_FLUSH_BIT];

	// ----------------------------------------------------------------
	// Global control
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			crstReq_r <= 1'b0; // Controller starts in reset
			flushCtl_r <= 1'b0;
			unsolEn_r <= 1'b0;
		end
		else if (ce)
		begin
			// Reset bit stays writeable; while not ready only a 1 is taken
			if (regWrEn && regByteEn[0] &&
				wordHit(regAddr, `ALG_OFS_GLOBAL_CTRL) &&
				(seqReady || regWrData[`ALG_GLOBAL_CONTROL_CRST_BIT]))
				crstReq_r <= regWrData[`ALG_GLOBAL_CONTROL_CRST_BIT];
			if (ctrlInRst)
			begin
				flushCtl_r <= 1'b0;
				unsolEn_r <= 1'b0;
			end
			else
			begin
				if (flushDone)
					flushCtl_r <= 1'b0;
				else if (wrGctl && gctlMerged[`ALG_GLOBAL_CONTROL_FLUSH_BIT])
					flushCtl_r <= 1'b1;
				if (wrGctl)
					unsolEn_r <= gctlMerged[`ALG_GLOBAL_CONTROL_UNSOL_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Flush status and unsolicited response gating
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			flushSts_r <= 1'b0;
			flushReq <= 1'b0;
			unsolRespPush <= 1'b0;
			unsolRespDrop <= 1'b0;
		end
		else if (ce)
		begin
			if (ctrlInRst)
				flushSts_r <= 1'b0;
			else if (flushDone && flushCtl_r)
				flushSts_r <= 1'b1; // set wins over clear
			else if (flushStsClr)
				flushSts_r <= 1'b0;
			// Request stands while the flush is open
			flushReq <= ~ctrlInRst & ~flushDone &
				(flushCtl_r | (wrGctl & gctlMerged[`ALG_GLOBAL_CONTROL_FLUSH_BIT]));
			unsolRespPush <= unsolRespValid & unsolEn_r & seqReady;
			unsolRespDrop <= unsolRespValid & ~(unsolEn_r & seqReady);
		end
	end

	// ----------------------------------------------------------------
	// Resume well: wake enables and line change flags
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wake_enable_r <= `ALG_WAKE_EN_RESET;
			line_state_change_status_r <= `ALG_STATE_STS_RESET;
			wakeEvent <= 1'b0;
		end
		else if (ce)
		begin
			if (wrWake)
				wake_enable_r <= wakeMerged[2:0];
			// New events win over a clear in the same cycle
			line_state_change_status_r <= (line_state_change_status_r & ~stateClr) | lineEvt;
			wakeEvent <= |(lineEvt & wake_enable_r);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt control and status
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			gie_r <= 1'b0;
			cie_r <= 1'b0;
			sie_r <= 8'h00;
		end
		else if (ce)
		begin
			// No power-state input; power-on reset and controller reset both clear these
			if (ctrlInRst)
			begin
				gie_r <= 1'b0;
				cie_r <= 1'b0;
				sie_r <= 8'h00;
			end
			else if (wrIrqCtl)
			begin
				gie_r <= irqMerged[`ALG_GIE_BIT];
				cie_r <= irqMerged[`ALG_CIE_BIT];
				sie_r <= irqMerged[7:0];
			end
		end
	end

	// Status causes, independent of the enables
	assign stream_irq_status = streamIocSts | streamFifoErrSts;
	assign controller_irq_status = respIrq | respOverrun | (|line_state_change_status_r);
	assign global_irq_status = controller_irq_status | (|stream_irq_status);

	// Interrupt output
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			irqOut <= 1'b0;
		else if (ce)
			irqOut <= seqReady & gie_r & ((cie_r & controller_irq_status) |
				(|(sie_r & stream_irq_status)));
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always @*
	begin
		readWord = 32'h0000_0000;
		case ({2'b00, regAddr[8:2]})
		`ALG_OFS_OUT_PAYLOAD >> 2:
			readWord = {`ALG_IN_PAYLOAD_VAL,
				`ALG_OUT_PAYLOAD_VAL};
		`ALG_OFS_GLOBAL_CTRL >> 2:
			readWord = {23'h0, unsolEn_r, 6'h0, flushCtl_r, seqReady};
		`ALG_OFS_WAKE_EN >> 2:
			readWord = {13'h0, line_state_change_status_r, 13'h0, wake_enable_r};
		`ALG_OFS_GLOBAL_STS >> 2:
			readWord = {30'h0, flushSts_r, 1'b0};
		`ALG_OFS_IRQ_CTRL >> 2:
			readWord = {gie_r, cie_r, 22'h0, sie_r};
		`ALG_OFS_IRQ_STS >> 2:
			readWord = {global_irq_status, controller_irq_status, 22'h0, stream_irq_status};
		default:
			readWord = 32'h0000_0000;
		endcase
	end

	// Reads answer zero while the controller is not ready
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			regRdData <= 32'h0000_0000;
			regAck <= 1'b0;
		end
		else if (ce)
		begin
			regAck <= anyAccess;
			if (regRdEn && seqReady)
				regRdData <= readWord;
			else
				regRdData <= 32'h0000_0000;
		end
	end

endmodule // alg_global_regs

/* tb/alg_global_regs_properties.sv */
// Port assertions for the global register set
`timescale 1ns/1ps
module alg_global_regs_properties (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire regWrEn,
	input wire regRdEn,
	input wire [8:0] regAddr,
	input wire [31:0] regWrData,
	input wire [3:0] regByteEn,
	input wire [31:0] regRdData,
	input wire regAck,
	input wire linkResetN,
	input wire linkEnable,
	input wire unsolRespValid,
	input wire unsolRespPush,
	input wire unsolRespDrop,
	input wire flushReq,
	input wire flushDone,
	input wire wakeEvent
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Control word write while operating
	wire ctlWr;
	assign ctlWr = ce && regWrEn && regAddr[8:2] == 7'h02 && regByteEn[0]
		&& linkEnable;
	AST_FLUSH_GO: assert property (
		ctlWr && regWrData[1:0] == 2'h3 && !flushDone |=> flushReq)
		else $error("flush did not start");
	AST_FLUSH_END: assert property (
		ce && flushReq && flushDone |=> !flushReq)
		else $error("flush not cleared on completion");
	AST_UNSOL: assert property (
		ce && linkEnable && unsolRespValid |=> unsolRespPush != unsolRespDrop)
		else $error("unsolicited response neither kept nor dropped");
	AST_ACK: assert property (
		ce |=> regAck == $past(regWrEn || regRdEn))
		else $error("ack does not follow access");
	AST_IDLE_READ: assert property (
		(ce && regRdEn && !linkEnable) ##1 !linkEnable
		|-> regRdData == 32'h0000_0000)
		else $error("read in reset returned data");
	AST_LINK_RST: assert property (
		ctlWr && !regWrData[0] |=> ##1 !linkResetN)
		else $error("link reset not asserted");
	AST_NOT_READY: assert property (
		!linkResetN && $past(!linkResetN) |-> !linkEnable)
		else $error("link enabled during link reset");
	AST_READY_LATE: assert property (
		$rose(linkEnable) |-> linkResetN && $past(linkResetN, 4))
		else $error("ready before link reset released");
	AST_WAKE_PULSE: assert property (
		ce && wakeEvent |=> !wakeEvent)
		else $error("wake pulse too long");
endmodule // alg_global_regs_properties

bind alg_global_regs alg_global_regs_properties u_chk (
	.clk_sys, .rst_n, .ce, .regWrEn, .regRdEn, .regAddr, .regWrData,
	.regByteEn, .regRdData, .regAck, .linkResetN, .linkEnable,
	.unsolRespValid, .unsolRespPush, .unsolRespDrop, .flushReq,
	.flushDone, .wakeEvent
);

/* tb/alg_codec_model.sv */
// Behavioural codec side of the serial audio link
`timescale 1ns/1ps
module alg_codec_model (
	input wire clk_sys,
	input wire linkOn,
	output reg linkBitClk,
	output reg [2:0] serialInLine,
	output reg unsolRespValid
);
	// Idle levels
	initial
	begin
		linkBitClk = 1'h0;
		serialInLine = 3'h0;
		unsolRespValid = 1'h0;
	end
	// Link clock, 400 ns period, still while the link is off
	always
	begin
		#200;
		if (linkOn)
			linkBitClk = ~linkBitClk;
	end
	// Line change away from the sampling edge
	task raise_line(input integer idx);
	begin
		@(negedge linkBitClk);
		serialInLine[idx] = 1'h1;
	end
	endtask
	// All lines back to idle, away from the sampling edge
	task lower_lines;
	begin
		@(negedge linkBitClk);
		serialInLine = 3'h0;
	end
	endtask
	// One-cycle unsolicited response offer
	task send_unsol;
	begin
		@(negedge clk_sys);
		unsolRespValid = 1'h1;
		@(negedge clk_sys);
		unsolRespValid = 1'h0;
	end
	endtask
endmodule // alg_codec_model

/* tb/tb_alg_global_regs.sv */
// Self-checking bench of the global register set
`timescale 1ns/1ps
module tb_alg_global_regs;
	logic clk_sys, rst_n, regWrEn, regRdEn, flushDone, respIrq;
	logic respOverrun, linkOn, ceOn;
	logic [8:0] regAddr;
	logic [31:0] regWrData, rv;
	logic [3:0] regByteEn;
	logic [7:0] streamIocSts, streamFifoErrSts;
	wire [31:0] regRdData;
	wire [2:0] serialInLine;
	wire regAck, linkBitClk, linkResetN, linkEnable, unsolRespValid;
	wire unsolRespPush, unsolRespDrop, flushReq, irqOut, wakeEvent;
	integer errTotal, totalChecks, cyc, wakeCnt, i;

	alg_global_regs #(.ENTER_EDGES(2), .EXIT_EDGES(2)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ceOn),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regByteEn(regByteEn),
		.regRdData(regRdData), .regAck(regAck),
		.linkBitClk(linkBitClk), .serialInLine(serialInLine),
		.linkResetN(linkResetN), .linkEnable(linkEnable),
		.unsolRespValid(unsolRespValid), .unsolRespPush(unsolRespPush),
		.unsolRespDrop(unsolRespDrop), .flushReq(flushReq),
		.flushDone(flushDone), .respIrq(respIrq),
		.respOverrun(respOverrun), .streamIocSts(streamIocSts),
		.streamFifoErrSts(streamFifoErrSts), .irqOut(irqOut),
		.wakeEvent(wakeEvent)
	);
	alg_codec_model u_codec (
		.clk_sys(clk_sys), .linkOn(linkOn), .linkBitClk(linkBitClk),
		.serialInLine(serialInLine), .unsolRespValid(unsolRespValid)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function logic [31:0] b2(input logic x, input logic y);
		b2 = {30'h0000_0000, x, y};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		totalChecks = totalChecks + 1;
		if (got !== exp)
		begin
			errTotal = errTotal + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// One register access, ack checked
	task acc(input logic w, input logic [8:0] a, input logic [31:0] d,
		input logic [3:0] be);
	begin
		@(negedge clk_sys);
		regWrEn = w;
		regRdEn = !w;
		regAddr = a;
		regWrData = d;
		regByteEn = be;
		// Answer stands from the taking edge to the next one
		@(negedge clk_sys);
		rv = regRdData;
		chk(b2(1'h0, regAck), 32'h0000_0001);
		regWrEn = 1'h0;
		regRdEn = 1'h0;
	end
	endtask
	task wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
		acc(1'h1, a, d, be);
	endtask
	task rdc(input logic [8:0] a, input logic [31:0] e);
	begin
		acc(1'h0, a, 32'h0000_0000, 4'hf);
		chk(rv, e);
	end
	endtask
	task irq_chk(input logic e);
	begin
		repeat (2) @(negedge clk_sys);
		chk(b2(1'h0, irqOut), b2(1'h0, e));
	end
	endtask
	// Leave reset and poll until ready
	task go_ready;
	begin
		wr(9'h008, 32'h0000_0001, 4'h1);
		for (i = 0; i < 40 && rv[0] !== 1'h1; i = i + 1)
			acc(1'h0, 9'h008, 32'h0000_0000, 4'hf);
		chk(rv, 32'h0000_0001);
	end
	endtask
	task endOfTest;
	begin
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// Clock, timeout and wake pulse count
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc = cyc + 1;
		if (wakeEvent === 1'h1)
			wakeCnt = wakeCnt + 1;
		if (cyc == 20000)
		begin
			errTotal = errTotal + 1;
			endOfTest;
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		{clk_sys, rst_n, regWrEn, regRdEn, flushDone} = 5'h00;
		{respIrq, respOverrun, regAddr, regWrData, regByteEn} = 0;
		{streamIocSts, streamFifoErrSts, rv} = 0;
		{errTotal, totalChecks, cyc, wakeCnt, i} = 0;
		linkOn = 1'h1;
		ceOn = 1'h1;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'h1;
		rdc(9'h004, 32'h0000_0000);
		wr(9'h020, 32'h8000_00ff, 4'hf);
		go_ready;
		chk(b2(linkResetN, linkEnable), 32'h0000_0003);
		rdc(9'h004, 32'h001d_003c);
		wr(9'h004, 32'hffff_ffff, 4'hf);
		rdc(9'h004, 32'h001d_003c);
		rdc(9'h020, 32'h0000_0000);
		// Clock enable low freezes the bank: a write is lost
		@(negedge clk_sys);
		ceOn = 1'h0;
		regWrEn = 1'h1;
		regAddr = 9'h020;
		regWrData = 32'hffff_ffff;
		regByteEn = 4'hf;
		@(negedge clk_sys);
		chk(b2(1'h0, regAck), 32'h0000_0000);
		regWrEn = 1'h0;
		ceOn = 1'h1;
		rdc(9'h020, 32'h0000_0000);
		u_codec.send_unsol;
		chk(b2(unsolRespPush, unsolRespDrop), 32'h0000_0001);
		wr(9'h008, 32'h0000_0101, 4'hf);
		u_codec.send_unsol;
		chk(b2(unsolRespPush, unsolRespDrop), 32'h0000_0002);
		// Flush with streams idle
		wr(9'h008, 32'h0000_0103, 4'hf);
		chk(b2(1'h0, flushReq), 32'h0000_0001);
		@(negedge clk_sys);
		flushDone = 1'h1;
		@(negedge clk_sys);
		flushDone = 1'h0;
		chk(b2(1'h0, flushReq), 32'h0000_0000);
		rdc(9'h010, 32'h0000_0002);
		rdc(9'h008, 32'h0000_0101);
		wr(9'h010, 32'h0000_0002, 4'h1);
		rdc(9'h010, 32'h0000_0000);
		// Line changes, wake on line 0 only
		wr(9'h00c, 32'h0000_0005, 4'h3);
		u_codec.raise_line(0);
		u_codec.raise_line(1);
		repeat (30) @(negedge clk_sys);
		chk(wakeCnt, 1);
		rdc(9'h00c, 32'h0003_0005);
		wr(9'h00c, 32'h0001_0000, 4'h4);
		rdc(9'h00c, 32'h0002_0005);
		// Interrupt status and gating
		rdc(9'h024, 32'hc000_0000);
		@(negedge clk_sys);
		streamIocSts = 8'h01;
		streamFifoErrSts = 8'h80;
		rdc(9'h024, 32'hc000_0081);
		irq_chk(1'h0);
		wr(9'h020, 32'h4000_0081, 4'hf);
		irq_chk(1'h0);
		wr(9'h020, 32'h8000_0040, 4'hf);
		irq_chk(1'h0);
		wr(9'h020, 32'h8000_0080, 4'hf);
		irq_chk(1'h1);
		@(negedge clk_sys);
		{streamIocSts, streamFifoErrSts} = 16'h0000;
		wr(9'h00c, 32'h0002_0000, 4'h4);
		rdc(9'h024, 32'h0000_0000);
		wr(9'h020, 32'hc000_0000, 4'hf);
		for (i = 0; i < 2; i = i + 1)
		begin
			@(negedge clk_sys);
			respIrq = (i == 0);
			respOverrun = (i == 1);
			rdc(9'h024, 32'hc000_0000);
			irq_chk(1'h1);
		end
		@(negedge clk_sys);
		respOverrun = 1'h0;
		irq_chk(1'h0);
		// Controller reset keeps resume bits
		u_codec.raise_line(2);
		repeat (30) @(negedge clk_sys);
		wr(9'h008, 32'h0000_0000, 4'h1);
		@(negedge clk_sys);
		chk(b2(linkResetN, linkEnable), 32'h0000_0000);
		rdc(9'h00c, 32'h0000_0000);
		repeat (40) @(negedge clk_sys);
		go_ready;
		rdc(9'h020, 32'h0000_0000);
		rdc(9'h008, 32'h0000_0001);
		rdc(9'h00c, 32'h0004_0005);
		// Power-on reset clears them; lines idle so no new events
		u_codec.lower_lines;
		repeat (30) @(negedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'h0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'h1;
		go_ready;
		rdc(9'h00c, 32'h0000_0000);
		endOfTest;
	end
endmodule // tb_alg_global_regs
